// File: verilog/bioxe_exec.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "bioxe_regs.svh"

// What this block does
// - Jump loads the 11-bit literal into program counter bits 10..0.
// - Jump fills program counter bits 12..11 from high latch bits 4..3.
// - Jump takes two cycles and leaves all status flags alone.
// - Increment-skip zero result inserts an idle slot; no flags change.
// - Target select 0 writes accumulator, 1 writes addressed register (0..127); literal OR writes accumulator for either select.
// - Plain increment adds one, routes by target select, updates nil flag.
// - Literal OR combines accumulator with literal into accumulator, updates nil flag.
// - Register OR combines accumulator with register, routes result, updates nil flag.
// - Left shift sends bit 7 to outshift, shifts in zero, updates flags.
module bioxe_exec (
  input  wire  logic                  i_clk_sys,       // Core clock, 25 MHz
  input  wire  logic                  i_rst,           // Async reset, active high
  input  wire  logic                  i_instr_valid,   // Instruction present
  input  wire  bioxe_pkg::bioxe_op_e  i_opcode,        // Decoded opcode
  input  wire  logic [10:0]           i_literal,       // Literal field
  input  wire  logic [6:0]            i_file_addr,     // File register address
  input  wire  logic                  i_target_sel,    // 0 accum, 1 register
  input  wire  logic [7:0]            i_file_rdata,    // Operand from register file
  input  wire  logic [7:0]            i_pc_high_latch, // Program counter high latch
  input  wire  logic [3:0]            i_reg_addr,      // Register port address
  input  wire  logic [7:0]            i_reg_wdata,     // Register port write data
  input  wire  logic                  i_reg_we,        // Register port write strobe
  input  wire  logic                  i_reg_re,        // Register port read strobe
  output logic                        o_instr_ready,   // Can take an instruction
  output logic                        o_flush,         // Idle slot, drop fetched word
  output logic [12:0]                 o_pc,            // Program counter
  output logic [7:0]                  o_accum,         // Accumulator
  output logic                        o_nil_flag,      // Nil result flag
  output logic                        o_outshift_flag, // Outshift bit
  output logic                        o_file_we,       // Register file write pulse
  output logic [6:0]                  o_file_addr,     // Register file write address
  output logic [7:0]                  o_file_wdata,    // Register file write data
  output logic [7:0]                  o_reg_rdata      // Register port read data
);
  import bioxe_pkg::*;

  bioxe_state_e      state_reg, state_next;
  logic [12:0]       pc_reg, pc_next;
  logic [7:0]        accum_reg, accum_next;
  logic              nil_reg, nil_next;
  logic              out_reg, out_next;
  logic              fwe_reg;
  logic [6:0]        faddr_reg;
  logic [7:0]        fdata_reg;
  logic [7:0]        rdata_reg, rdata_next;

  wire  [7:0]        alu_res;
  wire               alu_zero;
  wire               alu_shift;

  bioxe_alu u_alu (
    .i_op        (i_opcode),
    .i_accum     (accum_reg),
    .i_operand   (i_file_rdata),
    .i_literal   (i_literal[7:0]),
    .o_result    (alu_res),
    .o_zero      (alu_zero),
    .o_shift_out (alu_shift)
  );

  wire is_jump  = (i_opcode == OP_JUMP_ABSOLUTE);
  wire is_skip  = (i_opcode == OP_INCREMENT_SKIP_ON_ZERO);
  wire is_lit   = (i_opcode == OP_OR_LITERAL_INTO_ACCUM);
  wire is_shl   = (i_opcode == OP_SHIFT_LEFT_REGISTER);
  wire is_legal = (i_opcode != OP_RSVD_6) && (i_opcode != OP_RSVD_7);
  wire writes_z = is_legal && !is_jump && !is_skip;
  wire take     = i_instr_valid && (state_reg == ST_RUN);
  wire exec     = take && is_legal && !is_jump;
  // Literal OR always lands in the accumulator whatever the select bit says
  wire to_file  = exec && !is_lit && i_target_sel;
  wire to_accum = exec && (is_lit || !i_target_sel);
  wire skip_now = take && is_skip && alu_zero;
  wire sw_accum = i_reg_we && (i_reg_addr == `BIOXE_ADDR_ACCUM);
  wire sw_stat  = i_reg_we && (i_reg_addr == `BIOXE_ADDR_STATUS);

  wire [12:0] pc_jump = {i_pc_high_latch[`BIOXE_LATCH_HI:`BIOXE_LATCH_LO],
                         i_literal};

  always_comb begin
    if (take && is_jump) begin
      pc_next = pc_jump;
    end else if (skip_now) begin
      pc_next = pc_reg + `BIOXE_PC_SKIP_STEP;
    end else if (take) begin
      pc_next = pc_reg + `BIOXE_PC_STEP;
    end else begin
      pc_next = pc_reg;
    end
  end

  // Core update beats a software write landing in the same cycle
  assign accum_next = to_accum ? alu_res : (sw_accum ? i_reg_wdata : accum_reg);
  assign nil_next   = (take && writes_z) ? alu_zero :
                      (sw_stat ? i_reg_wdata[`BIOXE_STAT_NIL] : nil_reg);
  assign out_next   = (take && is_shl) ? alu_shift :
                      (sw_stat ? i_reg_wdata[`BIOXE_STAT_OUTSHIFT] : out_reg);
  assign state_next = (take && (is_jump || skip_now)) ? ST_HOLD : ST_RUN;

  always_comb begin
    rdata_next = `BIOXE_DATA_ZERO;
    unique case (i_reg_addr)
      `BIOXE_ADDR_ACCUM:  rdata_next = accum_reg;
      `BIOXE_ADDR_STATUS: rdata_next = {6'h00, out_reg, nil_reg};
      `BIOXE_ADDR_PC_LO:  rdata_next = pc_reg[`BIOXE_PC_HI_LO-1:0];
      `BIOXE_ADDR_PC_HI:  rdata_next = {3'h0, pc_reg[`BIOXE_PC_TOP_HI:`BIOXE_PC_HI_LO]};
      default:            rdata_next = `BIOXE_DATA_ZERO;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_RUN;
      pc_reg    <= `BIOXE_PC_RESET;
      accum_reg <= `BIOXE_ACCUM_RESET;
      nil_reg   <= 1'b0;
      out_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      accum_reg <= accum_next;
      nil_reg   <= nil_next;
      out_reg   <= out_next;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fwe_reg   <= 1'b0;
      faddr_reg <= 7'h00;
      fdata_reg <= `BIOXE_DATA_ZERO;
      rdata_reg <= `BIOXE_DATA_ZERO;
    end else begin
      fwe_reg   <= to_file;
      faddr_reg <= to_file ? i_file_addr : faddr_reg;
      fdata_reg <= to_file ? alu_res : fdata_reg;
      rdata_reg <= i_reg_re ? rdata_next : `BIOXE_DATA_ZERO;
    end
  end

  assign o_instr_ready   = (state_reg == ST_RUN);
  assign o_flush         = (state_reg == ST_HOLD);
  assign o_pc            = pc_reg;
  assign o_accum         = accum_reg;
  assign o_nil_flag      = nil_reg;
  assign o_outshift_flag = out_reg;
  assign o_file_we       = fwe_reg;
  assign o_file_addr     = faddr_reg;
  assign o_file_wdata    = fdata_reg;
  assign o_reg_rdata     = rdata_reg;

  // Select by the file strobe; the select bit has already moved on to the next word
  wire [7:0] dest_val = o_file_we ? o_file_wdata : o_accum;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_jump_low;
    take && is_jump |=> o_pc[`BIOXE_PC_LIT_HI:0] == $past(i_literal);
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump low pc wrong");

  property p_jump_high;
    take && is_jump |=> o_pc[`BIOXE_PC_TOP_HI:`BIOXE_PC_TOP_LO]
      == $past(i_pc_high_latch[`BIOXE_LATCH_HI:`BIOXE_LATCH_LO]);
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("jump high pc wrong");

  property p_jump_two;
    take && is_jump && !sw_stat |=> !o_instr_ready && $stable(o_nil_flag)
      && $stable(o_outshift_flag) ##1 o_instr_ready;
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump timing or flags");

  property p_skip;
    take && is_skip && !sw_stat |=> $stable(o_nil_flag) && $stable(o_outshift_flag)
      && (o_flush == $past(alu_zero)) ##1 !(o_flush && $past(o_flush));
  endproperty
  a_skip: assert property (p_skip) else $error("skip slot wrong");

  property p_dest;
    exec && !is_lit |=> o_file_we == $past(i_target_sel)
      && (!o_file_we || o_file_addr == $past(i_file_addr));
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");

  property p_inc;
    take && i_opcode == OP_INCREMENT_REGISTER |=>
      dest_val == $past(i_file_rdata) + `BIOXE_DATA_ONE;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_orlit;
    take && is_lit |=> o_accum == ($past(o_accum) | $past(i_literal[7:0]));
  endproperty
  a_orlit: assert property (p_orlit) else $error("literal or wrong");

  property p_orreg;
    take && i_opcode == OP_OR_ACCUM_WITH_REGISTER |=>
      dest_val == ($past(o_accum) | $past(i_file_rdata));
  endproperty
  a_orreg: assert property (p_orreg) else $error("register or wrong");

  property p_shl;
    take && is_shl |=> o_outshift_flag == $past(i_file_rdata[`BIOXE_MSB])
      && dest_val == {$past(i_file_rdata[`BIOXE_MSB-1:0]), 1'b0};
  endproperty
  a_shl: assert property (p_shl) else $error("shift wrong");

  property p_nil;
    take && writes_z |=> o_nil_flag == (dest_val == `BIOXE_DATA_ZERO);
  endproperty
  a_nil: assert property (p_nil) else $error("nil flag wrong");

  property p_one;
    take && !is_jump && !skip_now |=> o_instr_ready && !o_flush;
  endproperty
  a_one: assert property (p_one) else $error("not single cycle");

endmodule : bioxe_exec

// File: shared/bioxe_regs.svh
`ifndef BIOXE_REGS_SVH
`define BIOXE_REGS_SVH

`define BIOXE_PC_W          13
`define BIOXE_LIT_W         11
`define BIOXE_DATA_W        8
`define BIOXE_FADDR_W       7
`define BIOXE_RADDR_W       4
`define BIOXE_PC_RESET      13'h0000
`define BIOXE_PC_STEP       13'h0001
`define BIOXE_PC_SKIP_STEP  13'h0002
`define BIOXE_ACCUM_RESET   8'h00
`define BIOXE_DATA_ZERO     8'h00
`define BIOXE_DATA_ONE      8'h01
`define BIOXE_ADDR_ACCUM    4'h0
`define BIOXE_ADDR_STATUS   4'h4
`define BIOXE_ADDR_PC_LO    4'h8
`define BIOXE_ADDR_PC_HI    4'hc
`define BIOXE_STAT_NIL      0
`define BIOXE_STAT_OUTSHIFT 1
`define BIOXE_LATCH_HI      4
`define BIOXE_LATCH_LO      3
`define BIOXE_PC_LIT_HI     10
`define BIOXE_PC_TOP_HI     12
`define BIOXE_PC_TOP_LO     11
`define BIOXE_MSB           7
`define BIOXE_PC_HI_LO      8

`endif

// File: shared/bioxe_pkg.sv
package bioxe_pkg;

  typedef enum logic [2:0] {
    OP_JUMP_ABSOLUTE          = 3'h0,
    OP_INCREMENT_SKIP_ON_ZERO = 3'h1,
    OP_INCREMENT_REGISTER     = 3'h2,
    OP_OR_LITERAL_INTO_ACCUM  = 3'h3,
    OP_OR_ACCUM_WITH_REGISTER = 3'h4,
    OP_SHIFT_LEFT_REGISTER    = 3'h5,
    OP_RSVD_6                 = 3'h6,
    OP_RSVD_7                 = 3'h7
  } bioxe_op_e;

  typedef enum logic {
    ST_RUN  = 1'b0,
    ST_HOLD = 1'b1
  } bioxe_state_e;

endpackage : bioxe_pkg

// File: verilog/bioxe_alu.sv
`timescale 1ns/100ps
`include "bioxe_regs.svh"

module bioxe_alu (
  input  wire bioxe_pkg::bioxe_op_e   i_op,       // Decoded opcode
  input  wire logic [7:0]             i_accum,    // Accumulator
  input  wire logic [7:0]             i_operand,  // File register operand
  input  wire logic [7:0]             i_literal,  // Low literal byte
  output logic      [7:0]             o_result,   // Result byte
  output logic                        o_zero,     // Result is zero
  output logic                        o_shift_out // Bit shifted out
);
  import bioxe_pkg::*;

  always_comb begin
    o_result    = `BIOXE_DATA_ZERO;
    o_shift_out = 1'b0;
    unique case (i_op)
      OP_INCREMENT_SKIP_ON_ZERO,
      OP_INCREMENT_REGISTER:     o_result = i_operand + `BIOXE_DATA_ONE;
      OP_OR_LITERAL_INTO_ACCUM:  o_result = i_accum | i_literal;
      OP_OR_ACCUM_WITH_REGISTER: o_result = i_accum | i_operand;
      OP_SHIFT_LEFT_REGISTER: begin
        o_result    = {i_operand[`BIOXE_MSB-1:0], 1'b0};
        o_shift_out = i_operand[`BIOXE_MSB];
      end
      OP_JUMP_ABSOLUTE, OP_RSVD_6, OP_RSVD_7: o_result = `BIOXE_DATA_ZERO;
    endcase
  end

  assign o_zero = (o_result == `BIOXE_DATA_ZERO);

endmodule : bioxe_alu

// File: tb/tb_bioxe_exec.sv
`timescale 1ns/100ps
`include "bioxe_regs.svh"
`define CHK(nm, ex, gt) begin total_checks++; if ((ex) !== (gt)) begin miscompares++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, gt); end end

module tb_bioxe_exec;
  import bioxe_pkg::*;
  typedef struct packed {
    logic [12:0] pc;
    logic [7:0]  acc;
    logic        nil;
    logic        os;
    logic        hold;
    logic        we;
    logic [6:0]  fa;
    logic [7:0]  wd;
  } bioxe_exp_s;
  logic i_clk_sys, i_rst, i_instr_valid, i_target_sel, i_reg_we, i_reg_re;
  bioxe_op_e   i_opcode;
  logic [10:0] i_literal;
  logic [6:0]  i_file_addr, o_file_addr, fa_e;
  logic [7:0]  i_file_rdata, i_pc_high_latch, i_reg_wdata, o_accum, o_file_wdata, o_reg_rdata;
  logic [7:0]  acc_e, wd_e, ry;
  logic [3:0]  i_reg_addr;
  logic        o_instr_ready, o_flush, o_nil_flag, o_outshift_flag, o_file_we, nil_e, os_e;
  logic [12:0] o_pc, pc_e;
  logic        took = 1'b0;
  logic        rpend = 1'b0;
  int          miscompares, total_checks, i, j, k;
  integer      seed;
  logic [31:0] rv;
  bioxe_exp_s  eq[$], x;
  logic [7:0]  rq[$];
  bioxe_op_e   ops[3] = '{OP_INCREMENT_REGISTER, OP_OR_ACCUM_WITH_REGISTER, OP_SHIFT_LEFT_REGISTER};
  logic [7:0]  vals[4] = '{8'hff, 8'h80, 8'h00, 8'h37};

  bioxe_exec dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
    .i_opcode(i_opcode), .i_literal(i_literal), .i_file_addr(i_file_addr),
    .i_target_sel(i_target_sel), .i_file_rdata(i_file_rdata), .i_pc_high_latch(i_pc_high_latch),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_we(i_reg_we),
    .i_reg_re(i_reg_re), .o_instr_ready(o_instr_ready), .o_flush(o_flush), .o_pc(o_pc),
    .o_accum(o_accum), .o_nil_flag(o_nil_flag), .o_outshift_flag(o_outshift_flag),
    .o_file_we(o_file_we), .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata),
    .o_reg_rdata(o_reg_rdata));

  task automatic put(input logic v, input logic w, input logic r);
    i_instr_valid <= v;
    i_reg_we      <= w;
    i_reg_re      <= r;
  endtask : put

  task automatic instr(input bioxe_op_e op, input logic [10:0] lit, input logic [6:0] fa,
                       input logic sel, input logic [7:0] rd, input logic [7:0] lat);
    logic [7:0] r;
    logic       hold, we, dst, nu;
    r    = 8'h00;
    hold = 1'b0;
    we   = 1'b0;
    dst  = op inside {OP_INCREMENT_SKIP_ON_ZERO, OP_INCREMENT_REGISTER,
                      OP_OR_ACCUM_WITH_REGISTER, OP_SHIFT_LEFT_REGISTER};
    nu   = op inside {OP_INCREMENT_REGISTER, OP_OR_LITERAL_INTO_ACCUM,
                      OP_OR_ACCUM_WITH_REGISTER, OP_SHIFT_LEFT_REGISTER};
    case (op)
      OP_JUMP_ABSOLUTE:          hold = 1'b1;
      OP_INCREMENT_SKIP_ON_ZERO: begin
        r    = rd + 8'h01;
        hold = (r == 8'h00);
      end
      OP_INCREMENT_REGISTER:     r = rd + 8'h01;
      OP_OR_LITERAL_INTO_ACCUM:  acc_e = acc_e | lit[7:0];
      OP_OR_ACCUM_WITH_REGISTER: r = acc_e | rd;
      OP_SHIFT_LEFT_REGISTER:    begin
        r    = {rd[6:0], 1'b0};
        os_e = rd[`BIOXE_MSB];
      end
      default: ;
    endcase
    if (op == OP_OR_LITERAL_INTO_ACCUM) r = acc_e;
    if (nu) nil_e = (r == 8'h00);
    if (dst && sel) begin
      we   = 1'b1;
      fa_e = fa;
      wd_e = r;
    end else if (dst) acc_e = r;
    if (op == OP_JUMP_ABSOLUTE) pc_e = {lat[`BIOXE_LATCH_HI:`BIOXE_LATCH_LO], lit};
    else pc_e = pc_e + (hold ? 13'h0002 : 13'h0001);
    put(1'b1, 1'b0, 1'b0);
    i_opcode        <= op;
    i_literal       <= lit;
    i_file_addr     <= fa;
    i_target_sel    <= sel;
    i_file_rdata    <= rd;
    i_pc_high_latch <= lat;
    eq.push_back(bioxe_exp_s'{pc_e, acc_e, nil_e, os_e, hold, we, fa_e, wd_e});
    @(posedge i_clk_sys);
    if (hold) begin
      // Offered during the idle slot; must be ignored
      i_opcode  <= OP_OR_LITERAL_INTO_ACCUM;
      i_literal <= 11'h0ff;
      @(posedge i_clk_sys);
    end
  endtask : instr

  task automatic rd(input logic [3:0] a, input logic [7:0] ex);
    put(1'b0, 1'b0, 1'b1);
    i_reg_addr <= a;
    rq.push_back(ex);
    @(posedge i_clk_sys);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    put(1'b0, 1'b1, 1'b0);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    if (a == `BIOXE_ADDR_ACCUM) acc_e = d;
    if (a == `BIOXE_ADDR_STATUS) {os_e, nil_e} = d[1:0];
    @(posedge i_clk_sys);
  endtask : wr

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  always @(posedge i_clk_sys) begin
    took  <= i_instr_valid && o_instr_ready;
    rpend <= i_reg_re;
  end

  // Checks at the falling edge, once the rising-edge updates have landed
  always @(negedge i_clk_sys) begin
    if (took) begin
      if (eq.size() == 0) begin
        miscompares++;
        $display("unexpected result: expected none seen instruction");
      end else begin
        x = eq.pop_front();
        `CHK("pc", x.pc, o_pc)
        `CHK("accum", x.acc, o_accum)
        `CHK("nil", x.nil, o_nil_flag)
        `CHK("outshift", x.os, o_outshift_flag)
        `CHK("flush", x.hold, o_flush)
        `CHK("ready", ~x.hold, o_instr_ready)
        `CHK("file_we", x.we, o_file_we)
        if (x.we) `CHK("file_addr", x.fa, o_file_addr)
        if (x.we) `CHK("file_wdata", x.wd, o_file_wdata)
      end
    end else begin
      `CHK("idle we", 1'b0, o_file_we)
      `CHK("idle flush", 1'b0, o_flush)
      `CHK("idle ready", 1'b1, o_instr_ready)
    end
    if (rpend && rq.size() > 0) begin
      ry = rq.pop_front();
      `CHK("rdata", ry, o_reg_rdata)
    end else `CHK("idle rdata", 8'h00, o_reg_rdata)
  end

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    miscompares++;
    $display("unexpected timeout: expected end seen hang");
    conclude();
  end

  initial begin
    {i_instr_valid, i_target_sel, i_reg_we, i_reg_re, i_literal, i_file_addr} = '0;
    {i_file_rdata, i_pc_high_latch, i_reg_wdata, i_reg_addr} = '0;
    i_opcode = OP_JUMP_ABSOLUTE;
    {pc_e, acc_e, nil_e, os_e, fa_e, wd_e} = '0;
    seed = 32'h7c90;
    i_rst = 1'b1;
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'hc, 8'h00);
    rd(4'h2, 8'h00);
    $display("test reset_values done");
    for (i = 0; i < 4; i++) begin
      rv = $random(seed);
      instr(OP_JUMP_ABSOLUTE, (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : rv[10:0], 7'h00, 1'b0,
            8'h00, (rv[23:16] & 8'he7) | {3'h0, i[1:0], 3'h0});
      rd(4'h8, pc_e[7:0]);
      rd(4'hc, {3'h0, pc_e[12:8]});
    end
    $display("test jump done");
    wr(4'h4, 8'h03);
    instr(OP_INCREMENT_SKIP_ON_ZERO, 11'h000, 7'h7f, 1'b1, 8'hff, 8'h00);
    instr(OP_INCREMENT_SKIP_ON_ZERO, 11'h000, 7'h00, 1'b0, 8'hff, 8'h00);
    instr(OP_INCREMENT_SKIP_ON_ZERO, 11'h000, 7'h15, 1'b0, 8'h41, 8'h00);
    rd(4'h4, {6'h00, os_e, nil_e});
    $display("test skip done");
    wr(4'h0, 8'h00);
    for (i = 0; i < 3; i++)
      for (j = 0; j < 2; j++)
        for (k = 0; k < 4; k++)
          instr(ops[i], 11'h000, 7'(k * 42 + j), j[0], vals[k], 8'h00);
    $display("test alu_ops done");
    wr(4'h0, 8'h00);
    instr(OP_OR_LITERAL_INTO_ACCUM, 11'h700, 7'h01, 1'b1, 8'hff, 8'h00);
    instr(OP_OR_LITERAL_INTO_ACCUM, 11'h7a5, 7'h01, 1'b1, 8'h00, 8'h00);
    instr(OP_RSVD_6, 11'h000, 7'h00, 1'b1, 8'h00, 8'h00);
    instr(OP_RSVD_7, 11'h000, 7'h00, 1'b1, 8'h00, 8'h00);
    $display("test or_literal_reserved done");
    wr(4'h8, 8'hff);
    wr(4'h2, 8'hff);
    wr(4'h0, 8'h5a);
    rd(4'h0, 8'h5a);
    wr(4'h4, 8'h02);
    rd(4'h4, 8'h02);
    rd(4'h8, pc_e[7:0]);
    rd(4'h2, 8'h00);
    $display("test register_port done");
    for (i = 0; i < 40; i++) begin
      rv = $random(seed);
      instr(bioxe_op_e'(rv[2:0]), rv[13:3], rv[20:14], rv[21], rv[29:22], 8'($random(seed)));
    end
    put(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge i_clk_sys);
    `CHK("pending", 32'd0, 32'(eq.size() + rq.size()))
    $display("test random done");
    conclude();
  end
endmodule : tb_bioxe_exec
